//--- rtl/ncs_defines.svh
// constants for the nand command/status host controller
// Function
// R1: copy-back starts with read command then four source address cycles.
// R2: after ready, second copy-back command then target address cycles.
// R3: plane address bit in target equals the source value.
// R4: confirm command after target address starts device programming.
// R5: after status command each read cycle returns status byte.
// R6: status shown stays current while strobes held low.
// R7: status mode lasts until another command is written.
// R8: reselect main or spare area after status during random read.
// R9: identification entered by command plus one zero address cycle.
// R10: identification returns four bytes in fixed order.
// R11: identification mode lasts until next command.
// R12: reset aborts busy read, program or erase.
// R13: reset clears command register; status becomes C0h when write-guard high.
// R14: device ignores reset while still resetting.
// R15: ready/busy goes low for reset busy period after reset.
// R16: host waits recovery time after power-up before commands.
// R17: host holds write-guard low through power transitions.
// R18: ready/busy high idle, low while busy.
// R19: ready/busy is open-drain, shared wired-OR; the model drives it high and low.
// R20: status bit 6 reports ready/busy.
// R21: status bit 0 reports pass/fail, zero means pass.
// R22: reset while ready gives busy at most 5us.
// R23: write-guard low blocks program and erase.
// R24: commands with command latch high, addresses with address latch high.
// R25: host waits for ready before second copy-back command.
`ifndef NCS_DEFINES_SVH
`define NCS_DEFINES_SVH
`define NCS_CMD_READ_MAIN   8'h00
`define NCS_CMD_READ_SPARE  8'h50
`define NCS_CMD_COPY_DEST   8'h8A
`define NCS_CMD_CONFIRM     8'h10
`define NCS_CMD_STATUS      8'h70
`define NCS_CMD_READ_ID     8'h90
`define NCS_CMD_RESET       8'hFF
`define NCS_ID_ADDR         8'h00
`define NCS_ADDR_CYCLES     3'd4
`define NCS_ID_BYTES        3'd4
`define NCS_ST_READY_BIT    6
`define NCS_ST_FAIL_BIT     0
// plane bit is bit 0 of the fourth address byte
`define NCS_PLANE_BIT       24
`define NCS_PCLK_MHZ        125
`define NCS_RECOVERY_NS     10000
`define NCS_RECOVERY_CYC    ((`NCS_RECOVERY_NS * `NCS_PCLK_MHZ + 999) / 1000)
`define NCS_STROBE_NS       40
`define NCS_STROBE_CYC      ((`NCS_STROBE_NS * `NCS_PCLK_MHZ + 999) / 1000)
`define NCS_TWHR_NS         60
`define NCS_TWHR_CYC        ((`NCS_TWHR_NS * `NCS_PCLK_MHZ + 999) / 1000)
`define NCS_TWB_NS          100
`define NCS_TWB_CYC         ((`NCS_TWB_NS * `NCS_PCLK_MHZ + 999) / 1000)
`define NCS_REG_CTRL        12'h000
`define NCS_REG_SRC         12'h004
`define NCS_REG_DST         12'h008
`define NCS_REG_STAT        12'h00C
`define NCS_REG_ID          12'h010
`define NCS_OP_COPY         3'd1
`define NCS_OP_STATUS       3'd2
`define NCS_OP_ID           3'd3
`define NCS_OP_RESET        3'd4
`define NCS_OP_WG           3'd5
`endif

//--- rtl/ncs_pkg.sv
// types for the nand command/status host controller
package ncs_pkg;
  typedef enum logic [3:0] {
    NCS_IDLE   = 4'b0000,
    NCS_CMD    = 4'b0001,
    NCS_ADDR   = 4'b0010,
    NCS_TURN   = 4'b0011,
    NCS_RDATA  = 4'b0100,
    NCS_WAITB  = 4'b0101,
    NCS_WAITR  = 4'b0110,
    NCS_NEXT   = 4'b0111,
    NCS_POWER  = 4'b1000
  } ncs_state_type;
  typedef enum logic [1:0] {
    NCS_CYC_CMD  = 2'b00,
    NCS_CYC_ADDR = 2'b01,
    NCS_CYC_READ = 2'b10
  } ncs_cyc_type;
endpackage

//--- rtl/ncs_bus_cycle.sv
// one strobed bus cycle on the nand pins: command, address or read
`timescale 1ns/10ps
`include "ncs_defines.svh"
module ncs_bus_cycle #(
  parameter int STROBE_CYC = `NCS_STROBE_CYC
) (
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // request
  input  wire logic               start,
  input  wire ncs_pkg::ncs_cyc_type kind,
  input  wire logic [7:0]         wdata,
  output logic                    done,
  output logic [7:0]              rdata,
  // pins
  output logic                    cmd_latch,
  output logic                    addr_latch,
  output logic                    write_strobe_n,
  output logic                    read_strobe_n,
  output logic [7:0]              io_out,
  output logic                    io_oe,
  input  wire logic [7:0]         io_in
);
  logic [7:0] cnt_q, cnt_d;
  logic       act_q, act_d;
  logic [1:0] k_q, k_d;
  logic [7:0] dat_q, dat_d;
  logic [7:0] rdat_q, rdat_d;
  localparam logic [7:0] HALF   = 8'(STROBE_CYC);
  localparam logic [1:0] NCS_RD = 2'b10;

  always_comb
  begin
    cnt_d  = cnt_q;
    act_d  = act_q;
    k_d    = k_q;
    dat_d  = dat_q;
    rdat_d = rdat_q;
    done   = 1'b0;
    if (!act_q && start)
    begin
      act_d = 1'b1;
      k_d   = kind;
      dat_d = wdata;
      cnt_d = 8'h00;
    end
    else if (act_q)
    begin
      cnt_d = cnt_q + 8'h01;
      // sample while strobe still low; data not held past rising edge
      if (cnt_q == HALF - 8'h01 && k_q == NCS_RD)
        rdat_d = io_in;
      if (cnt_q == HALF + HALF - 8'h01)
      begin
        act_d = 1'b0;
        done  = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q  <= 8'h00;
      act_q  <= 1'b0;
      k_q    <= 2'b00;
      dat_q  <= 8'h00;
      rdat_q <= 8'h00;
    end
    else
    begin
      cnt_q  <= cnt_d;
      act_q  <= act_d;
      k_q    <= k_d;
      dat_q  <= dat_d;
      rdat_q <= rdat_d;
    end
  end

  logic low_phase;
  assign low_phase      = act_q && (cnt_q < HALF);
  assign cmd_latch      = act_q && (k_q == 2'b00);  // see R24
  assign addr_latch     = act_q && (k_q == 2'b01);  // see R24
  assign write_strobe_n = !(low_phase && k_q != NCS_RD);
  assign read_strobe_n  = !(low_phase && k_q == NCS_RD);
  assign io_out         = dat_q;
  assign io_oe          = act_q && (k_q != NCS_RD);
  assign rdata          = rdat_q;

  a_strobe_width: assert property (@(posedge pclk) disable iff (!presetn) // see R24
    $fell(write_strobe_n) |-> !write_strobe_n [*2]) else $error("write strobe too short");
  // latches still stand at the rising strobe, where the device captures
  a_latch_at_rise: assert property (@(posedge pclk) disable iff (!presetn) // see R24
    $rose(write_strobe_n) |-> (cmd_latch || addr_latch)) else $error("write strobe rose without latch enable");
endmodule

//--- rtl/ncs_host.sv
// apb-controlled host that sequences nand copy-back, status, id and reset
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/10ps
`include "ncs_defines.svh"
module ncs_host #(
  parameter int RECOVERY_CYC = `NCS_RECOVERY_CYC
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // nand pins
  output logic             chip_select_n,
  output logic             cmd_latch,
  output logic             addr_latch,
  output logic             write_strobe_n,
  output logic             read_strobe_n,
  output logic             write_guard_n,
  output logic [7:0]       io_out,
  output logic             io_oe,
  input  wire logic [7:0]  io_in,
  input  wire logic        ready_busy
);
  ncs_pkg::ncs_state_type st_q, st_d;
  ncs_pkg::ncs_cyc_type   kind;
  logic [2:0]  op_q, op_d;
  logic [2:0]  idx_q, idx_d;
  logic [1:0]  phase_q, phase_d;
  logic [31:0] src_q, src_d, dst_q, dst_d;
  logic [7:0]  stat_q, stat_d;
  logic [31:0] id_q, id_d;
  logic        wg_q, wg_d, err_q, err_d;
  logic [15:0] tmr_q, tmr_d;
  logic        go, bdone;
  logic [7:0]  bwdata, brdata;
  logic        wr, rd;

  assign wr      = psel && penable && pwrite;
  assign rd      = psel && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  function automatic logic [7:0] addr_byte(input logic [31:0] a, input logic [2:0] i);
    addr_byte = a[8*i +: 8];
  endfunction

  // copy-back cannot cross planes, so only the target's plane bit is overridden
  function automatic logic [31:0] dest_fix(input logic [31:0] d, input logic [31:0] s);
    dest_fix                 = d;
    dest_fix[`NCS_PLANE_BIT] = s[`NCS_PLANE_BIT];  // see R3
  endfunction

  always_comb
  begin
    st_d    = st_q;
    op_d    = op_q;
    idx_d   = idx_q;
    phase_d = phase_q;
    src_d   = src_q;
    dst_d   = dst_q;
    stat_d  = stat_q;
    id_d    = id_q;
    wg_d    = wg_q;
    err_d   = err_q;
    tmr_d   = tmr_q;
    go      = 1'b0;
    kind    = ncs_pkg::NCS_CYC_CMD;
    bwdata  = 8'h00;
    if (wr && paddr == `NCS_REG_SRC)
      src_d = pwdata;
    if (wr && paddr == `NCS_REG_DST)
      dst_d = pwdata;
    case (st_q)
      ncs_pkg::NCS_POWER:
      begin
        tmr_d = tmr_q + 16'h0001;
        if (tmr_q == 16'(RECOVERY_CYC))  // see R16
          st_d = ncs_pkg::NCS_IDLE;
      end
      ncs_pkg::NCS_IDLE:
        if (wr && paddr == `NCS_REG_CTRL)
        begin
          op_d = pwdata[2:0];
          phase_d = 2'd0;
          if (pwdata[2:0] == `NCS_OP_WG)
            wg_d = pwdata[8];  // see R17
          else if (pwdata[2:0] != 3'd0)
            st_d = ncs_pkg::NCS_CMD;
          if (pwdata[2:0] == `NCS_OP_COPY)
            dst_d = dest_fix(dst_q, src_q);
        end
      ncs_pkg::NCS_CMD:
      begin
        go = 1'b1;
        kind = ncs_pkg::NCS_CYC_CMD;
        // every copy opens with the main-area read, leaving any status mode behind
        case (op_q)
          `NCS_OP_COPY:   bwdata = phase_q == 2'd0 ? `NCS_CMD_READ_MAIN :   // see R1 R8
                                   phase_q == 2'd1 ? `NCS_CMD_COPY_DEST :   // see R2
                                   `NCS_CMD_CONFIRM;                        // see R4
          `NCS_OP_STATUS: bwdata = `NCS_CMD_STATUS;
          `NCS_OP_ID:     bwdata = `NCS_CMD_READ_ID;                        // see R9
          default:        bwdata = `NCS_CMD_RESET;
        endcase
        if (bdone)
        begin
          idx_d = 3'd0;
          tmr_d = 16'h0000;
          if (op_q == `NCS_OP_COPY && phase_q != 2'd2)
            st_d = ncs_pkg::NCS_ADDR;
          else if (op_q == `NCS_OP_ID)
            st_d = ncs_pkg::NCS_ADDR;
          else if (op_q == `NCS_OP_STATUS)
            st_d = ncs_pkg::NCS_TURN;
          else
            st_d = ncs_pkg::NCS_WAITB;
        end
      end
      ncs_pkg::NCS_ADDR:
      begin
        go = 1'b1;
        kind = ncs_pkg::NCS_CYC_ADDR;
        bwdata = op_q == `NCS_OP_ID ? `NCS_ID_ADDR :                      // see R9
                 phase_q == 2'd0 ? addr_byte(src_q, idx_q) : addr_byte(dst_q, idx_q);
        if (bdone)
        begin
          idx_d = idx_q + 3'd1;
          tmr_d = 16'h0000;
          if (op_q == `NCS_OP_ID)
            st_d = ncs_pkg::NCS_TURN;
          else if (idx_q == `NCS_ADDR_CYCLES - 3'd1)
            st_d = phase_q == 2'd0 ? ncs_pkg::NCS_WAITB : ncs_pkg::NCS_NEXT;
        end
      end
      ncs_pkg::NCS_TURN:
      begin
        tmr_d = tmr_q + 16'h0001;
        if (tmr_q == 16'(`NCS_TWHR_CYC))
        begin
          st_d = ncs_pkg::NCS_RDATA;
          idx_d = 3'd0;
        end
      end
      ncs_pkg::NCS_RDATA:
      begin
        go = 1'b1;
        kind = ncs_pkg::NCS_CYC_READ;
        if (bdone)
        begin
          idx_d = idx_q + 3'd1;
          if (op_q == `NCS_OP_STATUS)
          begin
            stat_d = brdata;
            st_d = ncs_pkg::NCS_IDLE;
          end
          else
          begin
            id_d = {brdata, id_q[31:8]};  // see R10
            if (idx_q == `NCS_ID_BYTES - 3'd1)
              st_d = ncs_pkg::NCS_IDLE;
          end
        end
      end
      ncs_pkg::NCS_WAITB:
      begin
        tmr_d = tmr_q + 16'h0001;
        if (tmr_q == 16'(`NCS_TWB_CYC))
          st_d = ncs_pkg::NCS_WAITR;
      end
      ncs_pkg::NCS_WAITR:
        if (ready_busy)  // see R25
        begin
          if (op_q == `NCS_OP_COPY && phase_q == 2'd0)
          begin
            phase_d = 2'd1;
            st_d = ncs_pkg::NCS_CMD;
          end
          else if (op_q == `NCS_OP_COPY)
          begin
            op_d = `NCS_OP_STATUS;
            st_d = ncs_pkg::NCS_CMD;
          end
          else
            st_d = ncs_pkg::NCS_IDLE;
        end
      ncs_pkg::NCS_NEXT:
      begin
        phase_d = 2'd2;
        st_d = ncs_pkg::NCS_CMD;
      end
      default:
        st_d = ncs_pkg::NCS_IDLE;
    endcase
    if (st_q == ncs_pkg::NCS_RDATA && bdone && op_q == `NCS_OP_STATUS)
      err_d = brdata[`NCS_ST_FAIL_BIT];  // see R21
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q    <= ncs_pkg::NCS_POWER;
      op_q    <= 3'd0;
      idx_q   <= 3'd0;
      phase_q <= 2'd0;
      src_q   <= 32'h0000_0000;
      dst_q   <= 32'h0000_0000;
      stat_q  <= 8'h00;
      id_q    <= 32'h0000_0000;
      wg_q    <= 1'b0;
      err_q   <= 1'b0;
      tmr_q   <= 16'h0000;
    end
    else
    begin
      st_q    <= st_d;
      op_q    <= op_d;
      idx_q   <= idx_d;
      phase_q <= phase_d;
      src_q   <= src_d;
      dst_q   <= dst_d;
      stat_q  <= stat_d;
      id_q    <= id_d;
      wg_q    <= wg_d;
      err_q   <= err_d;
      tmr_q   <= tmr_d;
    end
  end

  ncs_bus_cycle u_cyc (
    .pclk           (pclk),
    .presetn        (presetn),
    .start          (go),
    .kind           (kind),
    .wdata          (bwdata),
    .done           (bdone),
    .rdata          (brdata),
    .cmd_latch      (cmd_latch),
    .addr_latch     (addr_latch),
    .write_strobe_n (write_strobe_n),
    .read_strobe_n  (read_strobe_n),
    .io_out         (io_out),
    .io_oe          (io_oe),
    .io_in          (io_in)
  );

  assign chip_select_n = (st_q == ncs_pkg::NCS_IDLE) || (st_q == ncs_pkg::NCS_POWER);
  assign write_guard_n = wg_q;

  always_comb
  begin
    prdata = 32'h0000_0000;
    if (!rd)
      prdata = 32'h0000_0000;
    else if (paddr == `NCS_REG_CTRL)
      prdata = {23'h0, wg_q, 4'h0, st_q == ncs_pkg::NCS_IDLE, op_q};
    else if (paddr == `NCS_REG_SRC)
      prdata = src_q;
    else if (paddr == `NCS_REG_DST)
      prdata = dst_q;
    else if (paddr == `NCS_REG_STAT)
      prdata = {22'h0, ready_busy, err_q, stat_q};  // see R20
    else if (paddr == `NCS_REG_ID)
      prdata = id_q;
  end

  a_power_wait: assert property (@(posedge pclk) disable iff (!presetn) // see R16
    (st_q == ncs_pkg::NCS_POWER) |-> (chip_select_n && write_strobe_n && read_strobe_n))
    else $error("command before recovery");
  a_copy_ready: assert property (@(posedge pclk) disable iff (!presetn) // see R25
    (st_q == ncs_pkg::NCS_WAITR && op_q == 3'd1 && phase_q == 2'd0 && ready_busy)
    |=> (st_q == ncs_pkg::NCS_CMD && phase_q == 2'd1))
    else $error("second copy command not after ready");
  a_plane_same: assert property (@(posedge pclk) disable iff (!presetn) // see R3
    (st_q == ncs_pkg::NCS_ADDR && op_q == 3'd1 && phase_q == 2'd1) |-> dst_q[`NCS_PLANE_BIT] == src_q[`NCS_PLANE_BIT])
    else $error("plane bit differs");
  sequence s_target_last;
    st_q == ncs_pkg::NCS_ADDR && op_q == 3'd1 && phase_q == 2'd1 && idx_q == 3'd3 && bdone;
  endsequence
  sequence s_confirm_next;
    (st_q == ncs_pkg::NCS_NEXT) ##1 (st_q == ncs_pkg::NCS_CMD && phase_q == 2'd2);
  endsequence
  a_confirm_after: assert property (@(posedge pclk) disable iff (!presetn) // see R4
    s_target_last |=> s_confirm_next) else $error("confirm not after target address");
endmodule

//--- tb/ncs_nand_model.sv
// behavioural nand device answering the host controller
`timescale 1ns/10ps
module ncs_nand_model #(
  parameter logic [7:0] MAKER_CODE = 8'h5A, // arbitrary value
  parameter logic [7:0] DEV_CODE   = 8'h3C, // arbitrary value
  parameter logic [7:0] ID3_CODE   = 8'h11, // arbitrary value
  parameter logic [7:0] ID4_CODE   = 8'h22, // arbitrary value
  parameter int         READ_NS    = 3000,
  parameter int         PROG_NS    = 4000,
  parameter int         RST_NS     = 2000
) (
  // nand pins
  input  wire logic       chip_select_n,
  input  wire logic       cmd_latch,
  input  wire logic       addr_latch,
  input  wire logic       write_strobe_n,
  input  wire logic       read_strobe_n,
  input  wire logic       write_guard_n,
  input  wire logic [7:0] io_out,
  output logic [7:0]      io_in,
  output logic            ready_busy,
  // observation
  output logic [31:0]     dst_seen,
  output logic [7:0]      prog_cnt
);
  int          mode;
  int          acnt;
  int          idx;
  int          busy_ns;
  logic        busy;
  logic        resetting;
  logic [31:0] addr;
  logic [7:0]  last_out;
  logic [7:0]  rd_val;
  logic [7:0]  status_now;
  logic [7:0]  id_tab [4];
  initial
  begin
    mode = 0;
    acnt = 0;
    idx = 0;
    busy_ns = 0;
    busy = 1'b0;
    resetting = 1'b0;
    addr = '0;
    last_out = 8'h00;
    dst_seen = '0;
    prog_cnt = 8'h00;
    id_tab = '{MAKER_CODE, DEV_CODE, ID3_CODE, ID4_CODE};
  end
  // status follows busy live, so a held strobe sees updates
  assign status_now = {write_guard_n, ~busy, 5'h00, 1'b0};
  assign rd_val = (mode == 3) ? status_now : (mode == 4) ? id_tab[idx[1:0]] : 8'h00;
  // released bus shows the inverse of the last byte, never a stale copy
  assign io_in = (!chip_select_n && !read_strobe_n) ? rd_val : ~last_out;
  assign ready_busy = busy ? 1'b0 : 1'b1; // push-pull, driven high when not busy
  task automatic go_busy(input int ns);
    busy_ns = ns;
    busy = 1'b1;
  endtask
  always @(posedge busy)
  begin
    #(busy_ns);
    busy = 1'b0;
    resetting = 1'b0;
  end
  always @(posedge read_strobe_n)
  begin
    last_out = rd_val;
    if (mode == 4) idx = idx + 1;
  end
  always @(posedge write_strobe_n)
  begin
    if (!chip_select_n && cmd_latch)
    begin
      acnt = 0;
      case (io_out)
        8'h00: mode = 1;
        8'h8A: mode = 2;
        8'h70: mode = 3;
        8'h90: mode = 4;
        8'h10:
          if (mode == 2 && write_guard_n && !busy)
          begin
            prog_cnt = prog_cnt + 8'h01;
            go_busy(PROG_NS);
          end
        8'hFF:
          if (!resetting)
          begin
            mode = 0;
            resetting = 1'b1;
            go_busy(RST_NS);
          end
        default: mode = 0;
      endcase
    end
    else if (!chip_select_n && addr_latch)
    begin
      addr[acnt*8 +: 8] = io_out;
      acnt = acnt + 1;
      if (mode == 4) idx = 0;
      if (mode == 1 && acnt == 4) go_busy(READ_NS);
      if (mode == 2 && acnt == 4) dst_seen = addr;
    end
  end
endmodule

//--- tb/testbench.sv
// testbench driving the nand host over apb against the device model
`timescale 1ns/10ps
module testbench;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        chip_select_n;
  logic        cmd_latch;
  logic        addr_latch;
  logic        write_strobe_n;
  logic        read_strobe_n;
  logic        write_guard_n;
  logic [7:0]  io_out;
  logic        io_oe;
  logic [7:0]  io_in;
  logic        ready_busy;
  logic [31:0] dst_seen;
  logic [7:0]  prog_cnt;
  int          error_cnt;
  int          total_checks;
  int          busy_cyc;
  int          b0;
  initial pclk = 1'b0;
  always #4 pclk = ~pclk;
  always @(posedge pclk) if (ready_busy === 1'b0) busy_cyc++;
  ncs_host #(.RECOVERY_CYC(20)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chip_select_n(chip_select_n), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .write_guard_n(write_guard_n),
    .io_out(io_out), .io_oe(io_oe), .io_in(io_in), .ready_busy(ready_busy));
  ncs_nand_model u_dev (
    .chip_select_n(chip_select_n), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .write_guard_n(write_guard_n),
    .io_out(io_out), .io_in(io_in), .ready_busy(ready_busy), .dst_seen(dst_seen), .prog_cnt(prog_cnt));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      rd = prdata;
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    check("slave error", {31'h0, pslverr}, 32'h0);
  endtask
  // start an operation and poll the idle flag
  task automatic run_op(input logic [31:0] op);
    int n;
    apb(1'b1, 12'h000, op);
    n = 0;
    do
    begin
      apb(1'b0, 12'h000, 32'h0000_0000);
      n++;
    end while (rd[3] !== 1'b1 && n < 3000);
    check("op done", {31'h0, rd[3]}, 32'h1);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #(400000);
    error_cnt++;
    $display("Error watchdog expected done seen hang");
    finish_test();
  end
  initial
  begin
    error_cnt = 0;
    total_checks = 0;
    busy_cyc = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (30) @(posedge pclk);
    apb(1'b0, 12'h000, 32'h0);
    check("guard reset bit", rd & 32'h0000_0100, 32'h0);
    check("guard pin", {31'h0, write_guard_n}, 32'h0);
    $display("test reset done");
    run_op(32'h0000_0002);
    apb(1'b0, 12'h00C, 32'h0);
    check("status protected", rd, 32'h0000_0240);
    check("deselected when idle", {31'h0, chip_select_n}, 32'h1);
    check("bus released when idle", {31'h0, io_oe}, 32'h0);
    run_op(32'h0000_0105);
    check("guard pin", {31'h0, write_guard_n}, 32'h1);
    b0 = busy_cyc;
    run_op(32'h0000_0004);
    check("reset went busy", {31'h0, busy_cyc > b0}, 32'h1);
    run_op(32'h0000_0002);
    apb(1'b0, 12'h00C, 32'h0);
    check("status after reset", rd, 32'h0000_02C0);
    $display("test status reset done");
    repeat (2)
    begin
      run_op(32'h0000_0003);
      apb(1'b0, 12'h010, 32'h0);
      check("id bytes", rd, 32'h2211_3C5A);
    end
    $display("test id done");
    apb(1'b1, 12'h004, 32'h0123_4567);
    apb(1'b1, 12'h008, 32'h00AB_CDEF);
    run_op(32'h0000_0001);
    check("target address", dst_seen, 32'h01AB_CDEF);
    check("program count", {24'h0, prog_cnt}, 32'h1);
    apb(1'b0, 12'h00C, 32'h0);
    check("copy status", rd, 32'h0000_02C0);
    run_op(32'h0000_0005);
    run_op(32'h0000_0001);
    check("guarded program", {24'h0, prog_cnt}, 32'h1);
    $display("test copy done");
    apb(1'b0, 12'h020, 32'h0);
    check("unmapped read", rd, 32'h0);
    $display("test unmapped done");
    finish_test();
  end
endmodule
